// *** hdl/gpe_pin_detect.sv ***
/*
  interrupt trigger detector for one gpio line.
  assumes pin is synchronous to clk and clear is a one-cycle pulse.
*/
`timescale 1ns/1ps
module gpe_pin_detect
  import gpe_pkg::*;
(
  input wire logic clk, // bus clock
  input wire logic sys_rst, // async reset, high
  input wire logic pin, // pin level
  input wire gpe_det_cfg_t cfg, // sense, dual, pol, clear
  output logic raw // trigger detected
);
  gpe_det_st_t st;
  gpe_det_st_t next_st;
  logic rise;
  logic fall;
  logic hit;

  // ----------------------------------------------------------------
  // trigger detection
  // ----------------------------------------------------------------
  // armed holds off the first cycle so a pin high at reset is no edge
  always_comb begin
    next_st = st;
    rise = st.armed & ~st.prev & pin;
    fall = st.armed & st.prev & ~pin;
    hit = cfg.dual ? (rise | fall) :
                     (cfg.pol ? rise : fall);
    next_st.armed = 1'b1;
    next_st.prev = pin;
    // a new edge wins over a clear in the same cycle
    if (cfg.clear) begin
      next_st.latch = 1'b0;
    end
    if (hit) begin
      next_st.latch = 1'b1;
    end
    // level mode follows the pin, no clear needed
    next_st.raw = cfg.sense ? (pin == cfg.pol) :
                              next_st.latch;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign raw = st.raw;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_level_follow: assert property (
    cfg.sense |=> raw == $past(pin == cfg.pol))
    else $error("level status does not follow pin");
  a_edge_single: assert property (
    !cfg.sense && !cfg.dual && st.armed && (st.prev != pin)
    && (pin == cfg.pol) |=> raw)
    else $error("selected edge not latched");
  // the latch, not raw, is what a switch back from level mode shows
  a_edge_wrong: assert property (
    !cfg.sense && !cfg.dual && !st.latch && (pin != cfg.pol)
    |=> !raw)
    else $error("wrong edge latched");
  a_edge_dual: assert property (
    !cfg.sense && cfg.dual && st.armed && (st.prev != pin) |=> raw)
    else $error("dual edge not latched");
  a_edge_hold: assert property (
    !cfg.sense && raw && !cfg.clear && !$changed(cfg.sense) |=> raw)
    else $error("edge latch lost without clear");
  a_edge_clear: assert property (
    !cfg.sense && cfg.clear && (st.prev == pin) |=> !raw)
    else $error("clear did not drop latch");
endmodule // gpe_pin_detect

// *** hdl/gpe_pkg.sv ***
/*
  shared constants and carrier types for the eight-line gpio port.
  assumes an apb-style register port with byte addresses on paddr.
*/
package gpe_pkg;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int GPE_PINS = 8;
  localparam int GPE_AW = 12;
  localparam int GPE_DW = 32;
  localparam int MASK_LSB = 2;
  localparam int MASK_MSB = 9;
  localparam int REGION_LSB = 10;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [1:0] DATA_REGION = 2'h0;
  localparam logic [11:0] OFS_DIR = 12'h400;
  localparam logic [11:0] OFS_SENSE = 12'h404;
  localparam logic [11:0] OFS_DUAL = 12'h408;
  localparam logic [11:0] OFS_POL = 12'h40C;
  localparam logic [11:0] OFS_IE = 12'h410;
  localparam logic [11:0] OFS_RIS = 12'h414;
  localparam logic [11:0] OFS_MIS = 12'h418;
  localparam logic [11:0] OFS_IC = 12'h41C;
  localparam logic [11:0] OFS_AFSEL = 12'h420;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  // per-pin detector configuration
  typedef struct packed {
    logic sense;
    logic dual;
    logic pol;
    logic clear;
  } gpe_det_cfg_t;

  // detector state
  typedef struct packed {
    logic armed;
    logic prev;
    logic latch;
    logic raw;
  } gpe_det_st_t;

  // register block state
  typedef struct packed {
    logic [7:0] data;
    logic [7:0] dir;
    logic [7:0] sense;
    logic [7:0] dual;
    logic [7:0] pol;
    logic [7:0] ie;
    logic [7:0] afsel;
    logic [7:0] mis;
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    logic irq;
    logic ready;
    logic [31:0] prdata;
  } gpe_regs_t;
endpackage

// *** hdl/gpe_port.sv ***
/*
  eight-line gpio port with address-masked data access, direction,
  edge or level interrupts and per-pin hardware control.
  assumes an apb master on clk, pin_in synchronous to clk, and a
  peripheral driving hw_out and hw_oe.
*/
`timescale 1ns/1ps
module gpe_port
  import gpe_pkg::*;
(
  input wire logic clk, // bus clock
  input wire logic sys_rst, // async reset, high
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [GPE_AW-1:0] paddr, // apb byte address
  input wire logic [GPE_DW-1:0] pwdata, // apb write data
  output logic [GPE_DW-1:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, always low
  input wire logic [7:0] pin_in, // pin levels
  output logic [7:0] pin_out, // pin drive value
  output logic [7:0] pin_oe, // pin drive enable, high drives
  input wire logic [7:0] hw_out, // peripheral value
  input wire logic [7:0] hw_oe, // peripheral enable
  output logic [7:0] irq_masked_status, // per-pin interrupts
  output logic combined_irq // any pin interrupt
);
  gpe_regs_t st;
  gpe_regs_t next_st;
  logic [7:0] raw;
  logic [7:0] edge_clr;
  logic [7:0] mask;
  logic [7:0] pin_view;
  logic wr;
  logic rd_setup;
  logic is_data;
  logic err;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // writes commit in the access phase; reads are fetched in setup
  // so prdata is already a flop output when the master samples it
  assign wr = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign mask = paddr[MASK_MSB:MASK_LSB];
  assign is_data = paddr[GPE_AW-1:REGION_LSB] == DATA_REGION;
  // outputs come back from the stored data, inputs from the pin
  assign pin_view = (st.dir & st.data) | (~st.dir & pin_in);

  // ----------------------------------------------------------------
  // register next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    edge_clr = RST_BYTE;
    next_st.ready = 1'b1;
    // register writes
    if (wr) begin
      if (is_data) begin
        next_st.data = (st.data & ~mask) |
                       (pwdata[7:0] & mask);
      end else begin
        case (paddr)
          OFS_DIR: begin
            next_st.dir = pwdata[7:0];
          end
          OFS_SENSE: begin
            next_st.sense = pwdata[7:0];
          end
          OFS_DUAL: begin
            next_st.dual = pwdata[7:0];
          end
          OFS_POL: begin
            next_st.pol = pwdata[7:0];
          end
          OFS_IE: begin
            next_st.ie = pwdata[7:0];
          end
          OFS_IC: begin
            edge_clr = pwdata[7:0];
          end
          OFS_AFSEL: begin
            next_st.afsel = pwdata[7:0];
          end
          default: begin
          end
        endcase
      end
    end
    // register reads; unmapped and write-only read as zero
    if (rd_setup) begin
      next_st.prdata = RST_WORD;
      if (is_data) begin
        next_st.prdata[7:0] = pin_view & mask;
      end else begin
        case (paddr)
          OFS_DIR: begin
            next_st.prdata[7:0] = st.dir;
          end
          OFS_SENSE: begin
            next_st.prdata[7:0] = st.sense;
          end
          OFS_DUAL: begin
            next_st.prdata[7:0] = st.dual;
          end
          OFS_POL: begin
            next_st.prdata[7:0] = st.pol;
          end
          OFS_IE: begin
            next_st.prdata[7:0] = st.ie;
          end
          OFS_RIS: begin
            next_st.prdata[7:0] = raw;
          end
          OFS_MIS: begin
            next_st.prdata[7:0] = st.mis;
          end
          OFS_AFSEL: begin
            next_st.prdata[7:0] = st.afsel;
          end
          default: begin
          end
        endcase
      end
    end
    // pad drive: peripheral owns pins whose mode bit is set
    next_st.pin_out = (st.afsel & hw_out) |
                      (~st.afsel & st.data);
    next_st.pin_oe = (st.afsel & hw_oe) |
                     (~st.afsel & st.dir);
    // masking and the combined line share one source
    next_st.mis = raw & st.ie;
    next_st.irq = |(raw & st.ie);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // everything clears to zero, so all pins start as inputs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // per-pin detectors
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < GPE_PINS; gi++) begin : g_pin
      gpe_det_cfg_t cfg;
      assign cfg.sense = st.sense[gi];
      assign cfg.dual = st.dual[gi];
      assign cfg.pol = st.pol[gi];
      assign cfg.clear = edge_clr[gi];
      gpe_pin_detect u_det (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin(pin_in[gi]),
        .cfg(cfg),
        .raw(raw[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // err stays a constant-low flop; the port never refuses
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      err <= 1'b0;
    end else begin
      err <= 1'b0;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.ready;
  assign pslverr = err;
  assign pin_out = st.pin_out;
  assign pin_oe = st.pin_oe;
  assign irq_masked_status = st.mis;
  assign combined_irq = st.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_data_masked_wr: assert property (
    wr && is_data |=> st.data ==
      (($past(st.data) & ~$past(mask)) |
       ($past(pwdata[7:0]) & $past(mask))))
    else $error("masked data write wrong");

  a_data_read_mask: assert property (
    rd_setup && is_data |=>
      ((prdata[7:0] & ~$past(mask)) == RST_BYTE) &&
      (prdata[31:8] == RST_WORD[31:8]))
    else $error("masked-off data bits read nonzero");

  a_data_read_mix: assert property (
    rd_setup && is_data && (mask == '1) |=>
      prdata[7:0] == (($past(st.dir) & $past(st.data)) |
                      (~$past(st.dir) & $past(pin_in))))
    else $error("data read mixes pins wrongly");

  a_pin_drive_sw: assert property (
    wr && is_data && (mask == '1) && (st.afsel == RST_BYTE) &&
    (st.dir == '1) |=> ##1 pin_out == $past(pwdata[7:0], 2))
    else $error("written data not driven to pins");

  a_dir_to_oe: assert property (
    wr && (paddr == OFS_DIR) && (st.afsel == RST_BYTE) |=> ##1
      pin_oe == $past(pwdata[7:0], 2))
    else $error("direction write not seen on oe");

  a_hw_takeover: assert property (
    (st.afsel == '1) |=> pin_oe == $past(hw_oe) &&
      pin_out == $past(hw_out))
    else $error("hardware mode not passing peripheral");

  a_irq_mask: assert property (
    1'b1 |=> (irq_masked_status & ~$past(st.ie)) == RST_BYTE)
    else $error("disabled pin raised interrupt");

  a_mis_export: assert property (
    (|(raw & st.ie)) |=> irq_masked_status == $past(raw & st.ie))
    else $error("masked status not exported");

  a_irq_combined: assert property (
    combined_irq == (irq_masked_status != RST_BYTE))
    else $error("combined line disagrees with status");

  a_ris_read: assert property (
    rd_setup && (paddr == OFS_RIS) |=> prdata[7:0] == $past(raw))
    else $error("raw status read wrong");

  // ----------------------------------------------------------------
  // register write checks
  // ----------------------------------------------------------------
  // each config register takes the written low byte at the access
  // edge; a lost write would leave the pins on stale settings
  a_sense_write: assert property (
    wr && (paddr == OFS_SENSE) |=> st.sense == $past(pwdata[7:0]))
    else $error("sense select write lost");

  a_dual_write: assert property (
    wr && (paddr == OFS_DUAL) |=> st.dual == $past(pwdata[7:0]))
    else $error("dual edge write lost");

  a_pol_write: assert property (
    wr && (paddr == OFS_POL) |=> st.pol == $past(pwdata[7:0]))
    else $error("polarity write lost");

  a_ie_write: assert property (
    wr && (paddr == OFS_IE) |=> st.ie == $past(pwdata[7:0]))
    else $error("enable mask write lost");

  a_mode_write: assert property (
    wr && (paddr == OFS_AFSEL) |=> st.afsel == $past(pwdata[7:0]))
    else $error("mode select write lost");

  // writes outside the data region must leave the data alone
  a_data_guard: assert property (
    wr && !is_data |=> st.data == $past(st.data))
    else $error("data changed by another register");

  // ----------------------------------------------------------------
  // register read checks
  // ----------------------------------------------------------------
  // config reads give back the stored byte
  a_dir_read: assert property (
    rd_setup && (paddr == OFS_DIR) |=> prdata[7:0] == $past(st.dir))
    else $error("direction read wrong");

  a_mode_read: assert property (
    rd_setup && (paddr == OFS_AFSEL) |=> prdata[7:0] == $past(st.afsel))
    else $error("mode select read wrong");

  // the status and clear places are read-only or write-only views
  a_mis_read: assert property (
    rd_setup && (paddr == OFS_MIS) |=> prdata[7:0] == $past(st.mis))
    else $error("masked status read wrong");

  a_clear_reads_zero: assert property (
    rd_setup && (paddr == OFS_IC) |=> prdata == RST_WORD)
    else $error("write-only clear read nonzero");

  // only the low byte carries data; the rest must never float up
  a_upper_zero: assert property (
    prdata[31:8] == RST_WORD[31:8])
    else $error("unused read bits nonzero");

  // ----------------------------------------------------------------
  // drive and interrupt checks
  // ----------------------------------------------------------------
  // software mode hands the registers to the pads on the next edge
  a_sw_drive: assert property (
    (st.afsel == RST_BYTE) |=> pin_oe == $past(st.dir) &&
      pin_out == $past(st.data))
    else $error("software mode not driving registers");

  // with every pin masked the combined line stays quiet
  a_irq_quiet: assert property (
    (st.ie == RST_BYTE) |=> !combined_irq)
    else $error("combined line raised while all masked");

  // checked one edge on, so the first edge of power-up reset, where
  // the flops are still unknown, is not held against the design
  a_reset_clear: assert property (
    @(posedge clk) disable iff (1'b0)
    sys_rst |=> (pin_oe == RST_BYTE) && (st.data == RST_BYTE) &&
      (st.afsel == RST_BYTE) && (irq_masked_status == RST_BYTE) &&
      !combined_irq)
    else $error("state not cleared in reset");

  // scenarios the bench is meant to reach
  c_masked_write: cover property (
    wr && is_data && (mask != '1) && (mask != RST_BYTE));
  c_irq_rise: cover property ($rose(combined_irq));
  c_edge_clear: cover property (wr && (paddr == OFS_IC) &&
    (pwdata[7:0] != RST_BYTE));
  c_hw_mode: cover property ((st.afsel != RST_BYTE) &&
    (hw_oe != RST_BYTE));
  c_level_irq: cover property ((st.sense & st.ie & raw) != RST_BYTE);
endmodule // gpe_port

// *** test/gpe_pin_model.sv ***
/*
  pin-side partner: resolves each gpio line from the port drive and
  an external level chosen by the bench.
  assumes pin_out and pin_oe come straight from the port.
*/
`timescale 1ns/1ps
module gpe_pin_model (
  input wire logic [7:0] pin_out, // port drive value
  input wire logic [7:0] pin_oe, // port drive enable
  input wire logic [7:0] ext_lvl, // far-end level
  output logic [7:0] pin_in // resolved level
);
  // ----------------------------------------------------------------
  // pin resolution
  // ----------------------------------------------------------------
  // a driven line reads back its own drive
  // an undriven line shows the far end, never the stale drive
  assign pin_in = (pin_out & pin_oe) | (ext_lvl & ~pin_oe);
endmodule // gpe_pin_model

// *** test/tb_gpe_port.sv ***
/*
  self-checking bench for the gpio port: registers, masked data,
  pin control and interrupt detection.
  assumes the port package and the pin model are compiled first.
*/
`timescale 1ns/1ps
module tb_gpe_port;
  import gpe_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] pin_in;
  logic [7:0] pin_out;
  logic [7:0] pin_oe;
  logic [7:0] hw_out = 8'h00;
  logic [7:0] hw_oe = 8'h00;
  logic [7:0] ext_lvl = 8'h00;
  logic [7:0] irq_masked_status;
  logic combined_irq;
  logic [7:0] v, m, d, e, b, a, s, du, p, c, f, dreg;
  logic [31:0] q;
  logic [11:0] ofs [11];
  int miscompares = 0;
  int n_compared = 0;

  // 100 MHz clock
  always #5 clk = ~clk;

  gpe_port i_gpe_port (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .hw_out(hw_out), .hw_oe(hw_oe),
    .irq_masked_status(irq_masked_status),
    .combined_irq(combined_irq));
  gpe_pin_model i_gpe_pin_model (.pin_out(pin_out), .pin_oe(pin_oe),
    .ext_lvl(ext_lvl), .pin_in(pin_in));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // apb write: signals held until the access edge with pready high
  task automatic wr(input logic [11:0] ad, input logic [7:0] dt);
    @(posedge clk) #1;
    psel = 1'b1;
    pwrite = 1'b1;
    paddr = ad;
    pwdata = {24'h0, dt};
    @(posedge clk) #1;
    penable = 1'b1;
    @(posedge clk);
    chk("pready", {31'h0, pready}, 32'h1);
    #1;
    psel = 1'b0;
    penable = 1'b0;
  endtask

  // apb read: data taken at the access edge
  task automatic rd(input logic [11:0] ad, output logic [31:0] dt);
    @(posedge clk) #1;
    psel = 1'b1;
    pwrite = 1'b0;
    paddr = ad;
    @(posedge clk) #1;
    penable = 1'b1;
    @(posedge clk);
    dt = prdata;
    chk("pslverr", {31'h0, pslverr}, 32'h0);
    #1;
    psel = 1'b0;
    penable = 1'b0;
  endtask

  // expected trigger state after the lines move from bb to aa
  function automatic logic [7:0] trig(input logic [7:0] bb, aa, ss,
                                      dd, pp);
    trig = (ss & ((pp & aa) | (~pp & ~aa))) | (~ss & dd & (bb ^ aa))
         | (~ss & ~dd & ((pp & ~bb & aa) | (~pp & bb & ~aa)));
  endfunction

  // ----------------------------------------------------------------
  // watchdog: the whole run needs under a thousand cycles
  // ----------------------------------------------------------------
  initial begin
    #500000;
    miscompares++;
    final_report();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    ofs = '{OFS_DIR, OFS_SENSE, OFS_DUAL, OFS_POL, OFS_IE, OFS_AFSEL,
            OFS_RIS, OFS_MIS, OFS_IC, 12'h3FC, 12'h424};
    void'($urandom(32'h4db13a25));
    cyc(5);
    sys_rst = 1'b0;
    // reset values, write-only clear and unmapped place read as zero
    for (int i = 0; i < 11; i++) begin
      rd(ofs[i], q);
      chk("reset value", q, RST_WORD);
    end
    chk("oe after reset", {24'h0, pin_oe}, 32'h0);
    $display("test reset done");
    // configuration registers read back what was written
    for (int i = 0; i < 6; i++) begin
      v = $urandom;
      wr(ofs[i], v);
      rd(ofs[i], q);
      chk("config rw", q, {24'h0, v});
      wr(ofs[i], 8'h00);
    end
    $display("test config done");
    // masked data writes and reads with every line an output
    wr(OFS_DIR, 8'hFF);
    dreg = 8'h00;
    for (int i = 0; i < 10; i++) begin
      m = (i == 0) ? 8'h00 : $urandom;
      v = $urandom;
      wr({2'b00, m, 2'b00}, v);
      dreg = (dreg & ~m) | (v & m);
      cyc(2);
      chk("pin_out", {24'h0, pin_out}, {24'h0, dreg});
      m = $urandom;
      rd({2'b00, m, 2'b00}, q);
      chk("data read", q, {24'h0, dreg & m});
    end
    $display("test data done");
    // mixed directions: inputs read the line level
    for (int i = 0; i < 6; i++) begin
      d = $urandom;
      e = $urandom;
      ext_lvl = e;
      wr(OFS_DIR, d);
      cyc(2);
      chk("oe", {24'h0, pin_oe}, {24'h0, d});
      rd(12'h3FC, q);
      chk("data mix", q, {24'h0, (dreg & d) | (e & ~d)});
    end
    $display("test direction done");
    // hardware control takes drive and enable from the peripheral
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? 8'hFF : $urandom; // all pins handed over once
      hw_out = $urandom;
      hw_oe = $urandom;
      wr(OFS_AFSEL, a);
      cyc(2);
      e = (hw_oe & a) | (d & ~a);
      chk("hw oe", {24'h0, pin_oe}, {24'h0, e});
      v = (hw_out & a) | (dreg & ~a);
      chk("hw out", {24'h0, pin_out}, {24'h0, v});
    end
    wr(OFS_AFSEL, 8'h00);
    wr(OFS_DIR, 8'h00);
    $display("test hardware mode done");
    // interrupt detection over random sense, edge and polarity
    for (int i = 0; i < 16; i++) begin
      s = (i == 0) ? 8'h00 : $urandom;
      du = (i == 0) ? 8'h0F : $urandom;
      p = (i == 0) ? 8'h33 : $urandom;
      e = (i == 1) ? 8'h00 : $urandom;
      b = (i == 0) ? 8'h55 : $urandom;
      a = (i == 0) ? 8'hAA : $urandom;
      wr(OFS_SENSE, s);
      wr(OFS_DUAL, du);
      wr(OFS_POL, p);
      wr(OFS_IE, e);
      ext_lvl = b;
      cyc(3);
      wr(OFS_IC, 8'hFF);
      ext_lvl = a;
      cyc(3);
      f = trig(b, a, s, du, p);
      rd(OFS_RIS, q);
      chk("raw status", q, {24'h0, f});
      rd(OFS_MIS, q);
      chk("masked status", q, {24'h0, f & e});
      chk("irq lines", {24'h0, irq_masked_status},
          {24'h0, f & e});
      chk("combined", {31'h0, combined_irq},
          {31'h0, |(f & e)});
      c = $urandom;
      wr(OFS_IC, c);
      cyc(2);
      rd(OFS_RIS, q);
      chk("after clear", q, {24'h0, f & ~(c & ~s)});
    end
    $display("test interrupts done");
    // mid-run reset: move state away from zero, then pulse reset
    wr(OFS_DIR, 8'hFF);
    wr(OFS_AFSEL, 8'h0F);
    wr(12'h3FC, 8'hA5);
    wr(OFS_IE, 8'hFF);
    sys_rst = 1'b1;
    // lines held high through reset must not count as edges
    ext_lvl = 8'hFF;
    cyc(2);
    chk("oe in reset", {24'h0, pin_oe}, 32'h0);
    chk("out in reset", {24'h0, pin_out}, 32'h0);
    chk("irq in reset", {23'h0, combined_irq, irq_masked_status},
        32'h0);
    sys_rst = 1'b0;
    for (int i = 0; i < 9; i++) begin
      rd(ofs[i], q);
      chk("reset again", q, RST_WORD);
    end
    rd(12'h3FC, q);
    chk("inputs after reset", q, 32'h0000_00FF);
    wr(OFS_DIR, 8'hFF);
    rd(12'h3FC, q);
    chk("data after reset", q, RST_WORD);
    $display("test mid-run reset done");
    final_report();
  end
endmodule // tb_gpe_port
